// *** hdl/metering_pkg.sv ***
package metering_pkg;

  // Accumulation interval choices; the order is the menu order.
  typedef enum logic [2:0] {IV_OFF, IV_5, IV_10, IV_15, IV_30, IV_60} interval_t;

  typedef struct packed {
    interval_t interval;
    logic pulse_mode;
    logic cumulative;
    logic ref_supply;
    logic [13:0] act_scale;
    logic [13:0] react_scale;
  } settings_t;

  localparam int NUM_TOTALS = 4;
  localparam int IDX_ACT_DEM = 0;
  localparam int IDX_ACT_SUP = 1;
  localparam int IDX_REACT_DEM = 2;
  localparam int IDX_REACT_SUP = 3;

  localparam int SCALE_W = 14;
  localparam logic [13:0] SCALE_MIN = 14'h0001;
  localparam logic [13:0] SCALE_MAX = 14'h2710;
  localparam logic [13:0] SCALE_DEFAULT = 14'h0064;

  localparam int MINUTE_W = 11;
  localparam logic [10:0] MINUTES_5 = 11'h005;
  localparam logic [10:0] MINUTES_10 = 11'h00a;
  localparam logic [10:0] MINUTES_15 = 11'h00f;
  localparam logic [10:0] MINUTES_30 = 11'h01e;
  localparam logic [10:0] MINUTES_60 = 11'h03c;

  localparam settings_t SETTINGS_DEFAULT = '{
    interval: IV_30,
    pulse_mode: 1'b0,
    cumulative: 1'b0,
    ref_supply: 1'b0,
    act_scale: SCALE_DEFAULT,
    react_scale: SCALE_DEFAULT
  };

  function automatic logic [10:0] interval_minutes(input interval_t iv);
    logic [10:0] m;
    m = 11'h000;
    unique case (iv)
      IV_OFF: m = 11'h000;
      IV_5: m = MINUTES_5;
      IV_10: m = MINUTES_10;
      IV_15: m = MINUTES_15;
      IV_30: m = MINUTES_30;
      IV_60: m = MINUTES_60;
      default: m = 11'h000;
    endcase
    return m;
  endfunction : interval_minutes

  // Out-of-range weights are pulled into the legal range, never stored raw.
  function automatic logic [13:0] clamp_scale(input logic [13:0] s);
    logic [13:0] c;
    c = s;
    if (s < SCALE_MIN) c = SCALE_MIN;
    else if (s > SCALE_MAX) c = SCALE_MAX;
    return c;
  endfunction : clamp_scale

endpackage : metering_pkg

// *** hdl/accum_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface accum_if #(
  parameter int TW = 48,
  parameter int AW = 16
);
  logic clear;
  logic [3:0] add;
  logic [3:0][AW-1:0] amount;
  logic [3:0][TW-1:0] total;

  modport ctrl (output clear, output add, output amount, input total);
  modport bank (input clear, input add, input amount, output total);
endinterface : accum_if
`default_nettype wire

// *** hdl/total_accumulator_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
module total_accumulator_bank #(
  parameter int TW = 48,
  parameter int AW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  accum_if.bank acc
);

  typedef struct packed {
    logic [3:0][TW-1:0] total;
  } bank_state_t;

  bank_state_t s_r;
  bank_state_t s_nxt;
  logic [3:0][TW-1:0] total_nxt;

  // A clear restarts from this cycle's increment so no contribution is lost.
  for (genvar i = 0; i < 4; i++) begin : g_total
    assign total_nxt[i] = (acc.clear ? {TW{1'b0}} : s_r.total[i])
      + (acc.add[i] ? {{(TW-AW){1'b0}}, acc.amount[i]} : {TW{1'b0}});
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.total = total_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc.total = s_r.total;

endmodule : total_accumulator_bank
`default_nettype wire

// *** hdl/energy_metering_block.sv ***
`timescale 1ns/1ns
`default_nettype none
module energy_metering_block #(
  parameter int TW = 48,
  parameter int PW = 16,
  parameter logic UNIT_MEGA = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic settings_write_i,
  input wire metering_pkg::interval_t interval_sel_i,
  input wire logic pulse_source_i,
  input wire logic cumulative_i,
  input wire logic ref_supply_i,
  input wire logic [13:0] active_scale_i,
  input wire logic [13:0] reactive_scale_i,
  input wire logic totals_clear_in_i,
  input wire logic active_demand_pulse_in_i,
  input wire logic active_supply_pulse_in_i,
  input wire logic reactive_demand_pulse_in_i,
  input wire logic reactive_supply_pulse_in_i,
  input wire logic sample_valid_i,
  input wire logic signed [PW-1:0] active_power_i,
  input wire logic signed [PW-1:0] reactive_power_i,
  input wire logic rtc_minute_tick_i,
  input wire logic [10:0] rtc_minute_of_day_i,
  output logic [TW-1:0] active_demand_total_o,
  output logic [TW-1:0] active_supply_total_o,
  output logic [TW-1:0] reactive_demand_total_o,
  output logic [TW-1:0] reactive_supply_total_o,
  output logic report_valid_o,
  output logic [TW-1:0] report_active_demand_o,
  output logic [TW-1:0] report_active_supply_o,
  output logic [TW-1:0] report_reactive_demand_o,
  output logic [TW-1:0] report_reactive_supply_o,
  output metering_pkg::settings_t settings_o,
  output logic accumulating_o,
  output logic unit_mega_o
);

  localparam int AW = PW;

  typedef struct packed {
    metering_pkg::settings_t settings;
    logic armed;
    logic [3:0] pulse_prev;
    logic report_valid;
    logic [3:0][TW-1:0] report;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  metering_pkg::settings_t new_settings;
  logic settings_change;
  logic [10:0] mins;
  logic boundary;
  logic accumulating;
  logic [3:0] pulse_now;
  logic [3:0] pulse_rise;
  logic [AW-1:0] p_mag;
  logic [AW-1:0] q_mag;
  logic [3:0] raw_add;
  logic [3:0][AW-1:0] raw_amount;
  logic [AW-1:0] act_w;
  logic [AW-1:0] react_w;

  accum_if #(.TW(TW), .AW(AW)) acc ();

  total_accumulator_bank #(.TW(TW), .AW(AW)) u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .acc(acc)
  );

  assign pulse_now = {reactive_supply_pulse_in_i, reactive_demand_pulse_in_i,
                      active_supply_pulse_in_i, active_demand_pulse_in_i};
  assign act_w = AW'(s_r.settings.act_scale);
  assign react_w = AW'(s_r.settings.react_scale);

  always_comb begin
    s_nxt = s_r;
    s_nxt.report_valid = 1'b0;
    new_settings.interval = interval_sel_i;
    new_settings.pulse_mode = pulse_source_i;
    new_settings.cumulative = cumulative_i;
    new_settings.ref_supply = ref_supply_i;
    new_settings.act_scale = metering_pkg::clamp_scale(active_scale_i);
    new_settings.react_scale = metering_pkg::clamp_scale(reactive_scale_i);
    settings_change = settings_write_i && (new_settings != s_r.settings);
    mins = metering_pkg::interval_minutes(s_r.settings.interval);
    // A zero-minute interval means Off and never makes a boundary.
    boundary = rtc_minute_tick_i && (mins != 11'h000)
      && ((rtc_minute_of_day_i % mins) == 11'h000);
    pulse_rise = pulse_now & ~s_r.pulse_prev;
    s_nxt.pulse_prev = pulse_now;
    p_mag = active_power_i[PW-1] ? AW'(-active_power_i) : AW'(active_power_i);
    q_mag = reactive_power_i[PW-1] ? AW'(-reactive_power_i)
                                   : AW'(reactive_power_i);
    if (s_r.settings.pulse_mode) begin
      raw_add = pulse_rise;
      raw_amount = {react_w, react_w, act_w, act_w};
    end else begin
      // In-phase power lands on demand unless the reference is supply.
      raw_add[metering_pkg::IDX_ACT_DEM] = sample_valid_i && (p_mag != '0)
        && (active_power_i[PW-1] == s_r.settings.ref_supply);
      raw_add[metering_pkg::IDX_ACT_SUP] = sample_valid_i && (p_mag != '0)
        && (active_power_i[PW-1] != s_r.settings.ref_supply);
      raw_add[metering_pkg::IDX_REACT_DEM] = sample_valid_i && (q_mag != '0)
        && (reactive_power_i[PW-1] == s_r.settings.ref_supply);
      raw_add[metering_pkg::IDX_REACT_SUP] = sample_valid_i && (q_mag != '0)
        && (reactive_power_i[PW-1] != s_r.settings.ref_supply);
      raw_amount = {q_mag, q_mag, p_mag, p_mag};
    end
    accumulating = s_r.armed && (mins != 11'h000);
    acc.add = accumulating ? raw_add : 4'h0;
    acc.amount = raw_amount;
    acc.clear = 1'b0;
    if (settings_change) begin
      s_nxt.settings = new_settings;
      s_nxt.armed = 1'b0;
      acc.clear = 1'b1;
      acc.add = 4'h0;
    end else if (boundary) begin
      if (s_r.armed) begin
        s_nxt.report_valid = 1'b1;
        s_nxt.report = acc.total;
        // The increment of this cycle seeds the next interval.
        acc.clear = !s_r.settings.cumulative;
      end else begin
        s_nxt.armed = 1'b1;
      end
    end else if (s_r.settings.cumulative && totals_clear_in_i) begin
      acc.clear = 1'b1;
      acc.add = 4'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{settings: metering_pkg::SETTINGS_DEFAULT, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Totals wrap at the counter width, so TW must cover the longest run
  // between two clears.
  assign active_demand_total_o = acc.total[metering_pkg::IDX_ACT_DEM];
  assign active_supply_total_o = acc.total[metering_pkg::IDX_ACT_SUP];
  assign reactive_demand_total_o = acc.total[metering_pkg::IDX_REACT_DEM];
  assign reactive_supply_total_o = acc.total[metering_pkg::IDX_REACT_SUP];
  assign report_valid_o = s_r.report_valid;
  assign report_active_demand_o = s_r.report[metering_pkg::IDX_ACT_DEM];
  assign report_active_supply_o = s_r.report[metering_pkg::IDX_ACT_SUP];
  assign report_reactive_demand_o = s_r.report[metering_pkg::IDX_REACT_DEM];
  assign report_reactive_supply_o = s_r.report[metering_pkg::IDX_REACT_SUP];
  assign settings_o = s_r.settings;
  assign accumulating_o = accumulating;
  assign unit_mega_o = UNIT_MEGA;

  property p_off_silent;
    @(posedge clk_i) disable iff (rst_i)
    (s_r.settings.interval == metering_pkg::IV_OFF && !settings_change)
      |=> !report_valid_o && $stable(acc.total);
  endproperty
  a_off_silent: assert property (p_off_silent)
    else $error("Interval Off but totals or reports moved.");

  property p_change_zero;
    @(posedge clk_i) disable iff (rst_i)
    settings_change |=> (acc.total == '0) && !s_r.armed;
  endproperty
  a_change_zero: assert property (p_change_zero)
    else $error("Settings change did not zero totals.");

  property p_first_boundary_no_report;
    @(posedge clk_i) disable iff (rst_i)
    (boundary && !s_r.armed && !settings_change)
      |=> !report_valid_o && s_r.armed && (acc.total == '0);
  endproperty
  a_first_boundary_no_report: assert property (p_first_boundary_no_report)
    else $error("Report sent at the first boundary after a change.");

  property p_report_values;
    @(posedge clk_i) disable iff (rst_i)
    (boundary && s_r.armed && !settings_change)
      |=> report_valid_o && (s_r.report == $past(acc.total));
  endproperty
  a_report_values: assert property (p_report_values)
    else $error("Boundary report missing or wrong values.");

  property p_report_aligned;
    @(posedge clk_i) disable iff (rst_i)
    report_valid_o |-> $past(rtc_minute_tick_i)
      && (($past(rtc_minute_of_day_i) % $past(mins)) == 11'h000);
  endproperty
  a_report_aligned: assert property (p_report_aligned)
    else $error("Report not on an interval multiple.");

  property p_noncum_zero;
    @(posedge clk_i) disable iff (rst_i)
    (boundary && s_r.armed && !settings_change && !s_r.settings.cumulative
      && acc.add == 4'h0) |=> acc.total == '0;
  endproperty
  a_noncum_zero: assert property (p_noncum_zero)
    else $error("Totals not zeroed after a non-cumulative report.");

  property p_clear_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (totals_clear_in_i && !s_r.settings.cumulative && !settings_change
      && !boundary && acc.add == 4'h0) |=> $stable(acc.total);
  endproperty
  a_clear_ignored: assert property (p_clear_ignored)
    else $error("Totals-clear acted outside cumulative mode.");

  property p_pulse_weight;
    @(posedge clk_i) disable iff (rst_i)
    (s_r.settings.pulse_mode && accumulating && pulse_rise[0] && !acc.clear)
      |=> acc.total[0] == $past(acc.total[0])
        + TW'($past(s_r.settings.act_scale));
  endproperty
  a_pulse_weight: assert property (p_pulse_weight)
    else $error("Active demand pulse not weighted once.");

  property p_pulse_ignored;
    @(posedge clk_i) disable iff (rst_i)
    !s_r.settings.pulse_mode && !sample_valid_i |-> acc.add == 4'h0;
  endproperty
  a_pulse_ignored: assert property (p_pulse_ignored)
    else $error("Pulse counted while in computed mode.");

  property p_sign_split;
    @(posedge clk_i) disable iff (rst_i)
    (accumulating && !s_r.settings.pulse_mode && sample_valid_i)
      |-> !(acc.add[0] && acc.add[1]) && !(acc.add[2] && acc.add[3]);
  endproperty
  a_sign_split: assert property (p_sign_split)
    else $error("One sample fed both directions.");

  property p_report_hold;
    @(posedge clk_i) disable iff (rst_i)
    !report_valid_o |-> $stable(s_r.report);
  endproperty
  a_report_hold: assert property (p_report_hold)
    else $error("Report values moved between reports.");

  property p_report_armed;
    @(posedge clk_i) disable iff (rst_i)
    report_valid_o |-> $past(s_r.armed);
  endproperty
  a_report_armed: assert property (p_report_armed)
    else $error("Report sent from an unarmed interval.");

  property p_unarmed_idle;
    @(posedge clk_i) disable iff (rst_i)
    !s_r.armed |-> (acc.add == 4'h0) && !accumulating_o;
  endproperty
  a_unarmed_idle: assert property (p_unarmed_idle)
    else $error("Totals grew before the first boundary.");

  property p_rise_once;
    @(posedge clk_i) disable iff (rst_i)
    (s_r.settings.pulse_mode && pulse_now[0] && s_r.pulse_prev[0])
      |-> !acc.add[metering_pkg::IDX_ACT_DEM];
  endproperty
  a_rise_once: assert property (p_rise_once)
    else $error("A held pulse was counted again.");

  property p_clear_cum;
    @(posedge clk_i) disable iff (rst_i)
    (totals_clear_in_i && s_r.settings.cumulative && !settings_change
      && !boundary) |=> acc.total == '0;
  endproperty
  a_clear_cum: assert property (p_clear_cum)
    else $error("Totals-clear ignored in cumulative mode.");

  property p_scale_range;
    @(posedge clk_i) disable iff (rst_i)
    (settings_o.act_scale >= metering_pkg::SCALE_MIN)
      && (settings_o.act_scale <= metering_pkg::SCALE_MAX)
      && (settings_o.react_scale >= metering_pkg::SCALE_MIN)
      && (settings_o.react_scale <= metering_pkg::SCALE_MAX);
  endproperty
  a_scale_range: assert property (p_scale_range)
    else $error("Stored pulse weight outside its legal range.");

  property p_in_phase;
    @(posedge clk_i) disable iff (rst_i)
    (accumulating && !s_r.settings.pulse_mode && sample_valid_i
      && !settings_change && !active_power_i[PW-1] && (p_mag != '0))
      |-> acc.add[metering_pkg::IDX_ACT_DEM] == !s_r.settings.ref_supply;
  endproperty
  a_in_phase: assert property (p_in_phase)
    else $error("In-phase active power went to the wrong total.");

endmodule : energy_metering_block
`default_nettype wire

// *** testbench/meter_pulse_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module meter_pulse_model (
  input wire logic clk_i,
  output logic [3:0] pulse_o
);
  initial pulse_o = 4'h0;

  // A low gap follows every pulse, so the block never sees two pulses merge.
  task automatic fire(input int idx);
    @(negedge clk_i);
    pulse_o[idx] = 1'b1;
    @(negedge clk_i);
    pulse_o[idx] = 1'b0;
    @(negedge clk_i);
  endtask : fire
endmodule : meter_pulse_model
`default_nettype wire

// *** testbench/energy_metering_block_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module energy_metering_block_tb_top;
  localparam int TW = 48;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr, psrc, cum, refs, clr;
  logic sv, tick, rv, acc, mega;
  metering_pkg::interval_t iv;
  logic [13:0] ascl, rscl;
  logic signed [15:0] pwr_p, pwr_q;
  logic [10:0] minute;
  logic [3:0] pulses;
  logic [3:0][TW-1:0] tot, rep;
  metering_pkg::settings_t st;
  int bad_count = 0;
  int total_checks = 0;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  meter_pulse_model mdl (.clk_i(clk_i), .pulse_o(pulses));

  energy_metering_block dut (
    .clk_i(clk_i), .rst_i(rst_i), .settings_write_i(wr),
    .interval_sel_i(iv), .pulse_source_i(psrc), .cumulative_i(cum),
    .ref_supply_i(refs), .active_scale_i(ascl), .reactive_scale_i(rscl),
    .totals_clear_in_i(clr), .active_demand_pulse_in_i(pulses[0]),
    .active_supply_pulse_in_i(pulses[1]),
    .reactive_demand_pulse_in_i(pulses[2]),
    .reactive_supply_pulse_in_i(pulses[3]), .sample_valid_i(sv),
    .active_power_i(pwr_p), .reactive_power_i(pwr_q),
    .rtc_minute_tick_i(tick), .rtc_minute_of_day_i(minute),
    .active_demand_total_o(tot[0]), .active_supply_total_o(tot[1]),
    .reactive_demand_total_o(tot[2]), .reactive_supply_total_o(tot[3]),
    .report_valid_o(rv), .report_active_demand_o(rep[0]),
    .report_active_supply_o(rep[1]), .report_reactive_demand_o(rep[2]),
    .report_reactive_supply_o(rep[3]), .settings_o(st),
    .accumulating_o(acc), .unit_mega_o(mega));

  task automatic chk(input string what, input logic [TW-1:0] exp,
                     input logic [TW-1:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_tot(input logic [TW-1:0] a, b, c, d,
                         input logic [3:0][TW-1:0] got);
    chk("active demand", a, got[0]);
    chk("active supply", b, got[1]);
    chk("reactive demand", c, got[2]);
    chk("reactive supply", d, got[3]);
  endtask : chk_tot

  task automatic set_cfg(input metering_pkg::interval_t i,
                         input logic p, c, r, input logic [13:0] a, q);
    iv = i;
    psrc = p;
    cum = c;
    refs = r;
    ascl = a;
    rscl = q;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
    @(negedge clk_i);
  endtask : set_cfg

  // Returns in the cycle where a report pulse would stand.
  task automatic tick_at(input logic [10:0] m);
    minute = m;
    tick = 1'b1;
    @(negedge clk_i);
    tick = 1'b0;
  endtask : tick_at

  task automatic samp(input logic signed [15:0] p, q);
    pwr_p = p;
    pwr_q = q;
    sv = 1'b1;
    @(negedge clk_i);
    sv = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : samp

  task automatic pulse_clear();
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : pulse_clear

  task automatic t_reset();
    chk("settings", {14'h0000, metering_pkg::SETTINGS_DEFAULT}, st);
    chk_tot(48'h0, 48'h0, 48'h0, 48'h0, tot);
    chk("unit", 48'h0, mega);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pulse();
    set_cfg(metering_pkg::IV_15, 1'b1, 1'b0, 1'b0, 14'h0003, 14'h2710);
    chk("accumulating", 48'h0, acc);
    mdl.fire(0);
    chk("unarmed total", 48'h0, tot[0]);
    tick_at(11'h00f);
    chk("arming report", 48'h0, rv);
    chk("accumulating", 48'h1, acc);
    for (int i = 0; i < 4; i++) mdl.fire(i);
    chk_tot(48'h3, 48'h3, 48'h2710, 48'h2710, tot);
    tick_at(11'h014);
    chk("off-grid report", 48'h0, rv);
    @(negedge clk_i);
    tick_at(11'h01e);
    chk("report", 48'h1, rv);
    chk_tot(48'h3, 48'h3, 48'h2710, 48'h2710, rep);
    chk_tot(48'h0, 48'h0, 48'h0, 48'h0, tot);
    $display("test pulse done");
  endtask : t_pulse

  task automatic t_computed();
    set_cfg(metering_pkg::IV_5, 1'b0, 1'b0, 1'b0, 14'h0064, 14'h0064);
    tick_at(11'h005);
    samp(16'sh0007, -16'sh0004);
    mdl.fire(1);
    chk_tot(48'h7, 48'h0, 48'h0, 48'h4, tot);
    samp(-16'sh0002, 16'sh0009);
    chk_tot(48'h7, 48'h2, 48'h9, 48'h4, tot);
    set_cfg(metering_pkg::IV_5, 1'b0, 1'b0, 1'b1, 14'h0064, 14'h0064);
    chk_tot(48'h0, 48'h0, 48'h0, 48'h0, tot);
    samp(16'sh0005, 16'sh0000);
    chk("unarmed supply", 48'h0, tot[1]);
    tick_at(11'h00a);
    samp(16'sh0005, 16'sh0000);
    chk_tot(48'h0, 48'h5, 48'h0, 48'h0, tot);
    tick_at(11'h00f);
    chk("report", 48'h1, rv);
    chk("reported supply", 48'h5, rep[1]);
    $display("test computed done");
  endtask : t_computed

  task automatic t_cumulative();
    set_cfg(metering_pkg::IV_60, 1'b1, 1'b1, 1'b0, 14'h0000, 14'h3fff);
    tick_at(11'h03c);
    mdl.fire(0);
    mdl.fire(0);
    mdl.fire(2);
    chk_tot(48'h2, 48'h0, 48'h2710, 48'h0, tot);
    tick_at(11'h078);
    chk("report", 48'h1, rv);
    chk_tot(48'h2, 48'h0, 48'h2710, 48'h0, tot);
    pulse_clear();
    chk_tot(48'h0, 48'h0, 48'h0, 48'h0, tot);
    set_cfg(metering_pkg::IV_10, 1'b1, 1'b0, 1'b0, 14'h0001, 14'h0001);
    tick_at(11'h00a);
    mdl.fire(0);
    pulse_clear();
    chk("ignored clear", 48'h1, tot[0]);
    $display("test cumulative done");
  endtask : t_cumulative

  task automatic t_off();
    set_cfg(metering_pkg::IV_OFF, 1'b1, 1'b0, 1'b0, 14'h0001, 14'h0001);
    chk("accumulating", 48'h0, acc);
    tick_at(11'h000);
    chk("report", 48'h0, rv);
    mdl.fire(0);
    chk("off total", 48'h0, tot[0]);
    $display("test off done");
  endtask : t_off

  // A reset in mid-run must drop armed state and restore the defaults.
  task automatic t_midreset();
    set_cfg(metering_pkg::IV_10, 1'b1, 1'b1, 1'b1, 14'h0005, 14'h0005);
    tick_at(11'h014);
    mdl.fire(3);
    chk("pre-reset total", 48'h5, tot[3]);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk("settings", {14'h0000, metering_pkg::SETTINGS_DEFAULT}, st);
    chk_tot(48'h0, 48'h0, 48'h0, 48'h0, tot);
    chk("accumulating", 48'h0, acc);
    tick_at(11'h01e);
    chk("arming report", 48'h0, rv);
    chk("accumulating", 48'h1, acc);
    $display("test midreset done");
  endtask : t_midreset

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    iv = metering_pkg::IV_30;
    {wr, psrc, cum, refs, clr, sv, tick} = 7'h00;
    ascl = 14'h0064;
    rscl = 14'h0064;
    pwr_p = 16'sh0000;
    pwr_q = 16'sh0000;
    minute = 11'h000;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_pulse();
    t_computed();
    t_cumulative();
    t_off();
    t_midreset();
    end_of_test();
  end

  // The tests need under a hundred cycles; this margin only catches a hang.
  initial begin
    #(50 * 5000);
    bad_count++;
    end_of_test();
  end
endmodule : energy_metering_block_tb_top
`default_nettype wire
